/* File: bmc_pkg.sv */
package bmc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [4:0] BMC_OFFSET = 5'h00;
    localparam logic [15:0] BMC_RESET_VALUE = 16'h3100;
    localparam logic [15:0] BMC_WRITE_MASK = 16'hff80;
    localparam int BIT_SW_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED = 13;
    localparam int BIT_AN_ENABLE = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_AN_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SW_RESET_CYCLES = 16;
    localparam int COL_ASSERT_BIT_TIMES = 512;
    localparam int COL_DEASSERT_BIT_TIMES = 4;
    localparam int BIT_TIME_NS_100M = 10;
    // least bit-time bound at 100 Mbps, rounded down, at least one cycle
    localparam int COL_ASSERT_MAX_CYCLES =
        (COL_ASSERT_BIT_TIMES * BIT_TIME_NS_100M) / CLK_PERIOD_NS;
    localparam int COL_DEASSERT_MAX_CYCLES =
        ((COL_DEASSERT_BIT_TIMES * BIT_TIME_NS_100M) / CLK_PERIOD_NS) < 1
        ? 1 : (COL_DEASSERT_BIT_TIMES * BIT_TIME_NS_100M) / CLK_PERIOD_NS;
    localparam logic [4:0] SW_RESET_COUNT = 5'h10;

    typedef enum logic [1:0] {
        RST_IDLE,
        RST_RUN
    } sw_reset_state_t;
endpackage : bmc_pkg

/* File: phy_common_pinout_mode_mode_control.sv */
`timescale 1ns/1ps
// Contract
// - writing one to bit 15 resets PCS; bit reads one until done.
// - software reset leaves vendor-specific registers untouched.
// - loopback bit returns MAC transmit nibbles onto receive path.
// - with autoneg off, speed bit selects 10 or 100; resets one.
// - common-pinout mode: speed initialised from latched strap; here only when the autoneg strap is low.
// - autoneg enable initialised from latched strap in both modes.
// - autoneg on ignores speed and duplex bits; off they rule.
// - power down bit powers PHY functions down; resets zero.
// - during power down only management register access works; here the reference clock keeps running too.
// - power down is OR of bit and low pin; pin sets the bit; here the pin is ignored in common-pinout mode.
// - isolate disconnects MAC data interface, management stays alive.
// - isolated in RMII master mode stops reference clock output.
// - common-pinout mode: isolate initialised from latched strap.
// - restart writes ignored while autoneg disabled.
// - restart reads one until autoneg re-initiated, then clears.
// - management clearing restart never disturbs running autoneg.
// - duplex bit selects half or full; strap in common mode; resets one.
// - collision test asserts collision within 512 bit times of tx enable.
// - collision test drops collision within 4 bit times of tx end; here it drops up to two 50 ns clock cycles after tx end.
// - register holds 3100h after hardware reset before strap adjust.
module phy_common_pinout_mode_mode_control
    import bmc_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_REG_WR,
    input wire logic [4:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    output logic [15:0] O_REG_RDATA,
    input wire logic I_COMMON_PINOUT_MODE,
    input wire logic I_STRAP_SPEED,
    input wire logic I_STRAP_AN_ENABLE,
    input wire logic I_STRAP_ISOLATE,
    input wire logic I_STRAP_DUPLEX,
    input wire logic I_INTERRUPT_POWERDOWN_PIN_N,
    input wire logic I_RMII_MASTER,
    input wire logic I_AN_STARTED,
    input wire logic I_TX_EN,
    input wire logic [3:0] I_TXD,
    input wire logic [3:0] I_LINE_RXD,
    input wire logic I_LINE_RX_DV,
    input wire logic I_LINE_COL,
    input wire logic I_REF_CLK_50M,
    output logic [3:0] O_RXD,
    output logic O_RX_DV,
    output logic O_COL,
    output logic O_REF_CLK_50M,
    output logic O_PCS_RESET,
    output logic O_POWER_DOWN,
    output logic O_AN_ENABLE,
    output logic O_AN_RESTART,
    output logic O_SPEED_100,
    output logic O_FULL_DUPLEX
);
    // ****************************************************************
    // control register state
    // ****************************************************************
    logic [15:0] ctrl_reg, ctrl_next;
    logic strap_done_reg, strap_done_next;
    sw_reset_state_t rst_state_reg, rst_state_next;
    logic [4:0] rst_cnt_reg, rst_cnt_next;
    logic wr_hit;
    logic pin_pd;

    assign wr_hit = I_REG_WR && (I_REG_ADDR == BMC_OFFSET);
    assign pin_pd = I_COMMON_PINOUT_MODE ? 1'b0
                                         : !I_INTERRUPT_POWERDOWN_PIN_N;

    always_comb begin
        ctrl_next = ctrl_reg;
        strap_done_next = 1'b1;
        rst_state_next = rst_state_reg;
        rst_cnt_next = rst_cnt_reg;
        if (!strap_done_reg) begin
            // straps applied once, right after reset release
            ctrl_next[BIT_AN_ENABLE] = I_STRAP_AN_ENABLE;
            if (I_COMMON_PINOUT_MODE) begin
                ctrl_next[BIT_ISOLATE] = I_STRAP_ISOLATE;
                ctrl_next[BIT_DUPLEX] = I_STRAP_DUPLEX;
                if (!I_STRAP_AN_ENABLE) begin
                    ctrl_next[BIT_SPEED] = I_STRAP_SPEED;
                end
            end
        end else if (wr_hit) begin
            // reserved bits stay zero
            ctrl_next[14:10] = I_REG_WDATA[14:10];
            ctrl_next[BIT_DUPLEX] = I_REG_WDATA[BIT_DUPLEX];
            ctrl_next[BIT_COL_TEST] = I_REG_WDATA[BIT_COL_TEST];
            if (I_REG_WDATA[BIT_SW_RESET]) begin
                ctrl_next[BIT_SW_RESET] = 1'b1;
            end
            if (I_REG_WDATA[BIT_AN_ENABLE]) begin
                // writing zero clears only the bit, not autoneg itself
                ctrl_next[BIT_AN_RESTART] = I_REG_WDATA[BIT_AN_RESTART];
            end else begin
                ctrl_next[BIT_AN_RESTART] = 1'b0;
            end
        end
        if (ctrl_reg[BIT_AN_RESTART] && I_AN_STARTED) begin
            ctrl_next[BIT_AN_RESTART] = 1'b0;
        end
        if (pin_pd) begin
            ctrl_next[BIT_POWER_DOWN] = 1'b1;
        end
        case (rst_state_reg)
            RST_IDLE: begin
                if (ctrl_reg[BIT_SW_RESET]) begin
                    rst_state_next = RST_RUN;
                    rst_cnt_next = SW_RESET_COUNT;
                end
            end
            RST_RUN: begin
                if (rst_cnt_reg == 5'h00) begin
                    rst_state_next = RST_IDLE;
                    ctrl_next[BIT_SW_RESET] = 1'b0;
                end else begin
                    rst_cnt_next = rst_cnt_reg - 5'h01;
                end
            end
            default: begin
                rst_state_next = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            ctrl_reg <= BMC_RESET_VALUE;
            strap_done_reg <= 1'b0;
            rst_state_reg <= RST_IDLE;
            rst_cnt_reg <= 5'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            strap_done_reg <= strap_done_next;
            rst_state_reg <= rst_state_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    // ****************************************************************
    // collision test timing
    // ****************************************************************
    logic col_test_reg, col_test_next;

    always_comb begin
        col_test_next = ctrl_reg[BIT_COL_TEST] && I_TX_EN;
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            col_test_reg <= 1'b0;
        end else begin
            col_test_reg <= col_test_next;
        end
    end

    // ****************************************************************
    // data path toward the MAC
    // ****************************************************************
    logic [3:0] rxd_reg, rxd_next;
    logic rx_dv_reg, rx_dv_next;
    logic col_reg, col_next;
    logic power_down;
    logic isolate;

    // the data path toward the MAC idles while powered down; registers and reference clock keep running
    assign power_down = ctrl_reg[BIT_POWER_DOWN] || pin_pd;
    assign isolate = ctrl_reg[BIT_ISOLATE];

    always_comb begin
        rxd_next = 4'h0;
        rx_dv_next = 1'b0;
        col_next = 1'b0;
        if (!isolate && !power_down) begin
            if (ctrl_reg[BIT_LOOPBACK]) begin
                rxd_next = I_TXD;
                rx_dv_next = I_TX_EN;
            end else begin
                rxd_next = I_LINE_RXD;
                rx_dv_next = I_LINE_RX_DV;
            end
            col_next = ctrl_reg[BIT_COL_TEST] ? col_test_reg : I_LINE_COL;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            rxd_reg <= 4'h0;
            rx_dv_reg <= 1'b0;
            col_reg <= 1'b0;
        end else begin
            rxd_reg <= rxd_next;
            rx_dv_reg <= rx_dv_next;
            col_reg <= col_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign O_RXD = rxd_reg;
    assign O_RX_DV = rx_dv_reg;
    assign O_COL = col_reg;
    assign O_REF_CLK_50M = (isolate && I_RMII_MASTER) ? 1'b0
                                                      : I_REF_CLK_50M;
    // only the pcs is reset; vendor registers do not see this strobe
    assign O_PCS_RESET = (rst_state_reg == RST_RUN);
    assign O_POWER_DOWN = power_down;
    assign O_AN_ENABLE = ctrl_reg[BIT_AN_ENABLE];
    assign O_AN_RESTART = ctrl_reg[BIT_AN_RESTART] && ctrl_reg[BIT_AN_ENABLE];
    // while autoneg is enabled the outputs are forced to 100 Mbps and full duplex
    assign O_SPEED_100 = ctrl_reg[BIT_AN_ENABLE] ? 1'b1
                                                 : ctrl_reg[BIT_SPEED];
    assign O_FULL_DUPLEX = ctrl_reg[BIT_AN_ENABLE] ? 1'b1
                                                   : ctrl_reg[BIT_DUPLEX];
    assign O_REG_RDATA = (I_REG_ADDR == BMC_OFFSET)
                         ? (ctrl_reg & BMC_WRITE_MASK) : 16'h0000;
endmodule : phy_common_pinout_mode_mode_control

/* File: bmc_checker.sv */
`timescale 1ns/1ps
module bmc_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_REG_WR,
    input wire logic [4:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    input wire logic [15:0] O_REG_RDATA,
    input wire logic I_COMMON_PINOUT_MODE,
    input wire logic I_INTERRUPT_POWERDOWN_PIN_N,
    input wire logic I_RMII_MASTER,
    input wire logic I_TX_EN,
    input wire logic [3:0] I_TXD,
    input wire logic [3:0] O_RXD,
    input wire logic O_COL,
    input wire logic O_REF_CLK_50M,
    input wire logic O_PCS_RESET,
    input wire logic O_POWER_DOWN
);
    // ************************************************************
    // register and port checks
    // ************************************************************
    // 512 bit times at 100 Mbps in 50 ns cycles
    localparam int COL_RISE_MAX = 102;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);
    wire a0 = I_REG_ADDR == 5'h00;
    wire [15:0] r = O_REG_RDATA;
    sequence loop_on;
        a0 && r[14] && !r[10] && !O_POWER_DOWN;
    endsequence
    sequence rst_req;
        I_REG_WR && a0 && I_REG_WDATA[15];
    endsequence
    reserved_zero_a: assert property (r[6:0] == 7'h00)
        else $error("reserved bits read nonzero");
    power_or_a: assert property (a0 |-> O_POWER_DOWN == (r[11] ||
        (!I_INTERRUPT_POWERDOWN_PIN_N && !I_COMMON_PINOUT_MODE)))
        else $error("power down request wrong");
    iso_clock_a: assert property (a0 && r[10] && I_RMII_MASTER
        |-> !O_REF_CLK_50M) else $error("reference clock not stopped");
    loop_data_a: assert property (loop_on ##1 loop_on
        |-> O_RXD == $past(I_TXD)) else $error("loopback data wrong");
    col_rise_a: assert property (a0 && r[7] && $rose(I_TX_EN)
        |-> ##[1:COL_RISE_MAX] O_COL) else $error("collision late");
    col_fall_a: assert property (a0 && r[7] && $fell(I_TX_EN)
        |-> ##[1:2] !O_COL) else $error("collision not released");
    sw_reset_a: assert property (rst_req |=> r[15] ##1 O_PCS_RESET[*8])
        else $error("software reset not running");
    sw_done_a: assert property (O_PCS_RESET |-> ##[1:20] !O_PCS_RESET)
        else $error("software reset never ends");
    restart_off_a: assert property (I_REG_WR && a0 &&
        !I_REG_WDATA[12] |=> !a0 || !r[9]) else $error("restart kept");
endmodule : bmc_checker

bind phy_common_pinout_mode_mode_control bmc_checker bmc_checker_i (
    .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_REG_WR(I_REG_WR),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .O_REG_RDATA(O_REG_RDATA), .I_COMMON_PINOUT_MODE(I_COMMON_PINOUT_MODE),
    .I_INTERRUPT_POWERDOWN_PIN_N(I_INTERRUPT_POWERDOWN_PIN_N),
    .I_RMII_MASTER(I_RMII_MASTER), .I_TX_EN(I_TX_EN), .I_TXD(I_TXD),
    .O_RXD(O_RXD), .O_COL(O_COL), .O_REF_CLK_50M(O_REF_CLK_50M),
    .O_PCS_RESET(O_PCS_RESET), .O_POWER_DOWN(O_POWER_DOWN));

/* File: mac_model.sv */
`timescale 1ns/1ps
module mac_model (
    input wire logic i_clk,
    input wire logic i_send,
    output logic o_tx_en,
    output logic [3:0] o_txd
);
    logic go_reg = 1'b0;
    initial o_tx_en = 1'b0;
    initial o_txd = 4'h0;
    always @(posedge i_clk) go_reg <= i_send;
    // idle nibbles toggle so a stale value never looks valid
    always @(negedge i_clk) begin
        o_tx_en <= go_reg;
        o_txd <= go_reg ? o_txd + 4'h3 : ~o_txd;
    end
endmodule : mac_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, cmode = 1'b0, s_spd = 1'b1;
    logic s_an = 1'b1, s_iso = 1'b0, s_dup = 1'b1, pin_n = 1'b1, rmii = 1'b0;
    logic an_go = 1'b0, send = 1'b0, refc = 1'b1, tx_en, rx_dv, col, refo;
    logic pcs, pd, spd, fdx, an_en, an_rs;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [3:0] lrx = 4'h5, txd, rxd, prev;
    int n_fail = 0, checks = 0, cyc = 0, k;
    always #25 clk = ~clk;
    mac_model mac_model_i (.i_clk(clk), .i_send(send), .o_tx_en(tx_en),
        .o_txd(txd));
    phy_common_pinout_mode_mode_control phy_common_pinout_mode_mode_control_i (
        .I_SYS_CLK(clk), .I_RESETN(rstn), .I_REG_WR(wr), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .I_COMMON_PINOUT_MODE(cmode), .I_STRAP_SPEED(s_spd),
        .I_STRAP_AN_ENABLE(s_an), .I_STRAP_ISOLATE(s_iso),
        .I_STRAP_DUPLEX(s_dup), .I_INTERRUPT_POWERDOWN_PIN_N(pin_n),
        .I_RMII_MASTER(rmii), .I_AN_STARTED(an_go), .I_TX_EN(tx_en),
        .I_TXD(txd), .I_LINE_RXD(lrx), .I_LINE_RX_DV(1'b0),
        .I_LINE_COL(1'b0), .I_REF_CLK_50M(refc), .O_RXD(rxd),
        .O_RX_DV(rx_dv), .O_COL(col), .O_REF_CLK_50M(refo),
        .O_PCS_RESET(pcs), .O_POWER_DOWN(pd), .O_AN_ENABLE(an_en),
        .O_AN_RESTART(an_rs), .O_SPEED_100(spd), .O_FULL_DUPLEX(fdx));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr_reg(input logic [15:0] d);
        // writes are spaced by at least one idle cycle
        @(negedge clk);
        wr = 1'b1;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        addr = a;
        #1;
        cmp(rdata, exp);
        addr = 5'h00;
    endtask : rd
    task automatic rst_dut;
        rstn = 1'b0;
        tick(4);
        rstn = 1'b1;
        tick(1);
    endtask : rst_dut
    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        rst_dut();
        rd(5'h00, 16'h3100);
        rd(5'h05, 16'h0000);
        cmode = 1'b1;
        s_an = 1'b0;
        s_spd = 1'b0;
        s_dup = 1'b0;
        s_iso = 1'b1;
        rst_dut();
        rd(5'h00, 16'h0400);
        cmode = 1'b0;
        wr_reg(16'h7fff);
        rd(5'h00, 16'h7f80);
        cmp({14'h0, an_en, an_rs}, 16'h0003);
        an_go = 1'b1;
        tick(1);
        an_go = 1'b0;
        rd(5'h00, 16'h7d80);
        cmp({14'h0, an_en, an_rs}, 16'h0002);
        wr_reg(16'h0200);
        rd(5'h00, 16'h0000);
        cmp({14'h0, spd, fdx}, 16'h0000);
        wr_reg(16'h2100);
        cmp({14'h0, spd, fdx}, 16'h0003);
        // self-test pattern lives outside this block; loopback and duplex bits are set
        wr_reg(16'h4100);
        send = 1'b1;
        tick(2);
        #1;
        for (k = 0; k < 6; k++) begin
            prev = txd;
            @(negedge clk);
            #1;
            cmp({12'h0, rxd}, {12'h0, prev});
        end
        cmp({15'h0, rx_dv}, 16'h0001);
        send = 1'b0;
        wr_reg(16'h0080);
        send = 1'b1;
        k = 0;
        while (col !== 1'b1 && k < 110) begin
            @(negedge clk);
            k++;
        end
        cmp({15'h0, col}, 16'h0001);
        send = 1'b0;
        tick(4);
        cmp({15'h0, col}, 16'h0000);
        rmii = 1'b1;
        wr_reg(16'h0400);
        tick(2);
        cmp({10'h0, rx_dv, refo, rxd}, 16'h0000);
        rmii = 1'b0;
        pin_n = 1'b0;
        tick(2);
        cmp({14'h0, pd, rdata[11]}, 16'h0003);
        pin_n = 1'b1;
        wr_reg(16'h0000);
        cmp({15'h0, pd}, 16'h0000);
        wr_reg(16'h8000);
        cmp(rdata & 16'h8000, 16'h8000);
        tick(20);
        cmp({14'h0, pcs, rdata[15]}, 16'h0000);
        print_verdict();
    end
endmodule : tb
